// ### inc/irq_flags_pkg.sv
// Package with the register map, field positions and reset values of the interrupt flag logic.
package irq_flags_pkg;

	// Register indices as printed; byte address is four times the index.
	localparam logic [7:0] IDX_CORE_CTRL = 8'h0b;
	localparam logic [7:0] IDX_PFLAGS_ONE = 8'h0c;
	localparam logic [7:0] IDX_PFLAGS_TWO = 8'h0d;
	localparam logic [7:0] IDX_PEN_ONE = 8'h8c;
	localparam logic [7:0] IDX_PEN_TWO = 8'h8d;
	localparam logic [7:0] IDX_PIN_CHANGE_EN = 8'h96;
	localparam logic [7:0] IDX_TIMER2_PERIOD = 8'h92;
	localparam logic [7:0] IDX_EDGE_SELECT = 8'h81;
	localparam logic [7:0] IDX_TX_DATA = 8'h19;
	localparam logic [7:0] IDX_RX_DATA = 8'h1a;

	// Core control register fields.
	localparam int GIE_BIT = 7;
	localparam int PGE_BIT = 6;
	localparam int T0_EN_BIT = 5;
	localparam int EXT_EN_BIT = 4;
	localparam int PC_EN_BIT = 3;
	localparam int T0_FLAG_BIT = 2;
	localparam int EXT_FLAG_BIT = 1;
	localparam int PC_FLAG_BIT = 0;

	// First peripheral flag register fields.
	localparam int MEMW_BIT = 7;
	localparam int CONV_BIT = 6;
	localparam int RX_BIT = 5;
	localparam int TX_BIT = 4;
	localparam int SYNC_BIT = 3;
	localparam int CC1_BIT = 2;
	localparam int T2_BIT = 1;
	localparam int T1_BIT = 0;

	// Second peripheral flag register fields.
	localparam int OSC_BIT = 7;
	localparam int CMP2_BIT = 6;
	localparam int CMP1_BIT = 5;
	localparam int DISP_BIT = 4;
	localparam int LVD_BIT = 2;
	localparam int CC2_BIT = 0;

	// Implemented bits of the second pair, and software-writable flag bits.
	localparam logic [7:0] TWO_IMPL_MASK = 8'hf5;
	localparam logic [7:0] ONE_SW_MASK = 8'hcf;
	localparam logic [7:0] TWO_SW_MASK = 8'he5;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'hff;
	localparam logic [5:0] PIN_EN_RESET = 6'h00;

	// Capture/compare modes.
	typedef enum logic [1:0] {
		CC_CAPTURE,
		CC_COMPARE,
		CC_PWM,
		CC_OFF
	} capcmp_mode_t;

	// Event pulses from the peripherals, one cycle each; the display interrupt is held as a level.
	typedef struct packed {
		logic timer0_roll;
		logic timer1_roll;
		logic cc1_capture;
		logic cc1_match;
		logic cc2_capture;
		logic cc2_match;
		logic mem_write_done;
		logic conversion_done;
		logic sync_port_done;
		logic osc_fail;
		logic low_voltage;
		logic display_irq;
	} event_pulses_t;

endpackage : irq_flags_pkg

// ### core/irq_flag_logic.sv
// Interrupt enable and request-flag logic with an Avalon-MM register slave.
//
// Behaviour
// - Global enable gates every request.
// - Group enable gates all peripheral requests.
// - Peripheral source needs group and own enable.
// - Flags set regardless of global, group or own enable.
// - Flags other than receive, transmit and display stay set until software writes zero.
// - Timer0 rollover sets its flag.
// - Selected external pin edge sets flag.
// - Change on port pins 5..0 sets flag.
// - Port change also needs per-pin enable.
// - Receive flag follows buffer full, read clears.
// - Transmit flag follows buffer empty, write clears.
// - Capture or compare per mode sets flag.
// - Timer2 equal to period sets flag.
// - Timer1 overflow sets its flag.
// - Memory write and conversion done set flags.
// - Synchronous port completion sets its flag.
// - Oscillator failure sets its flag.
// - Comparator output changes set flags.
// - Display flag mirrors display interrupt.
// - Low voltage and second capture set flags.
// - Enables align with flags; bits 3,1 unimplemented.
`timescale 1ns/1ps
module irq_flag_logic
	import irq_flags_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_pin,
	input wire logic [5:0] port_pins,
	input wire logic comparator_one_output,
	input wire logic comparator_two_output,
	input wire event_pulses_t events,
	input wire capcmp_mode_t cc1_mode,
	input wire capcmp_mode_t cc2_mode,
	input wire logic [7:0] timer2_count,
	input wire logic serial_rx_full,
	input wire logic serial_tx_empty,
	output logic serial_rx_data_read,
	output logic serial_tx_data_write,
	output logic core_irq_request
);

	////////////////////////////////////////////////////////////////////////////////
	// Register storage.
	logic [7:0] core_interrupt_control;
	logic [7:0] peripheral_flags_one;
	logic [7:0] peripheral_flags_two;
	logic [7:0] peripheral_enables_one;
	logic [7:0] peripheral_enables_two;
	logic [5:0] per_pin_change_enable;
	logic [7:0] timer2_period;
	logic ext_rising_edge;
	logic ack;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode: one wait cycle, then the access is acknowledged.
	wire access = (avs_read | avs_write) & ~ack;
	wire lane0 = avs_byteenable[0];
	wire wr = avs_write & ack & lane0;
	wire rd = avs_read & ack;
	wire [7:0] idx = avs_address[9:2];
	wire [7:0] wd = avs_writedata[7:0];
	wire sel_core = idx == IDX_CORE_CTRL;
	wire sel_f1 = idx == IDX_PFLAGS_ONE;
	wire sel_f2 = idx == IDX_PFLAGS_TWO;
	wire sel_e1 = idx == IDX_PEN_ONE;
	wire sel_e2 = idx == IDX_PEN_TWO;
	wire sel_pin = idx == IDX_PIN_CHANGE_EN;
	wire sel_per = idx == IDX_TIMER2_PERIOD;
	wire sel_edge = idx == IDX_EDGE_SELECT;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

	// Acknowledge one cycle after the request appears.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack <= 1'b0;
		end else begin
			ack <= access;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; the first stage is read only by the second.
	logic [7:0] sync_a;
	logic [7:0] sync_b;
	logic [7:0] sync_c;
	wire [7:0] pins_in = {comparator_two_output, comparator_one_output, port_pins};
	logic ext_a;
	logic ext_b;
	logic ext_c;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_a <= RESET_BYTE;
			sync_b <= RESET_BYTE;
			sync_c <= RESET_BYTE;
			ext_a <= 1'b0;
			ext_b <= 1'b0;
			ext_c <= 1'b0;
		end else begin
			sync_a <= pins_in;
			sync_b <= sync_a;
			sync_c <= sync_b;
			ext_a <= ext_pin;
			ext_b <= ext_a;
			ext_c <= ext_b;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event detection.
	wire [5:0] pin_changed = sync_b[5:0] ^ sync_c[5:0];
	wire port_change_evt = |(pin_changed & per_pin_change_enable);
	wire ext_edge_evt = ext_rising_edge ? (ext_b & ~ext_c) : (~ext_b & ext_c);
	wire cmp1_evt = sync_b[6] ^ sync_c[6];
	wire cmp2_evt = sync_b[7] ^ sync_c[7];
	wire cc1_evt = (cc1_mode == CC_CAPTURE & events.cc1_capture)
		| (cc1_mode == CC_COMPARE & events.cc1_match);
	wire cc2_evt = (cc2_mode == CC_CAPTURE & events.cc2_capture)
		| (cc2_mode == CC_COMPARE & events.cc2_match);
	logic t2_equal_q;
	wire t2_equal = timer2_count == timer2_period;
	wire t2_evt = t2_equal & ~t2_equal_q;

	// Sticky-flag set vectors.
	wire [7:0] core_set = {5'h00, events.timer0_roll, ext_edge_evt, port_change_evt};
	wire [7:0] one_set = {events.mem_write_done, events.conversion_done, 2'b00,
		events.sync_port_done, cc1_evt, t2_evt, events.timer1_roll};
	wire [7:0] two_set = {events.osc_fail, cmp2_evt, cmp1_evt, 2'b00,
		events.low_voltage, 1'b0, cc2_evt};

	////////////////////////////////////////////////////////////////////////////////
	// Next flag values: software write of zero clears, a same-cycle event wins.
	wire [7:0] core_keep = (wr & sel_core) ? wd : core_interrupt_control;
	wire [7:0] one_keep = (wr & sel_f1) ? wd : peripheral_flags_one;
	wire [7:0] two_keep = (wr & sel_f2) ? wd : peripheral_flags_two;
	wire [7:0] next_core = core_keep | core_set;
	wire [7:0] next_one_sw = (one_keep | one_set) & ONE_SW_MASK;
	wire [7:0] next_two_sw = (two_keep | two_set) & TWO_SW_MASK;
	wire [7:0] one_live = {2'b00, serial_rx_full, serial_tx_empty, 4'h0};
	wire [7:0] two_live = {3'b000, events.display_irq, 4'h0};

	// Flag registers and the timer2 equality delay.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_interrupt_control <= RESET_BYTE;
			peripheral_flags_one <= RESET_BYTE;
			peripheral_flags_two <= RESET_BYTE;
			t2_equal_q <= 1'b0;
		end else begin
			core_interrupt_control <= next_core;
			peripheral_flags_one <= next_one_sw | one_live;
			peripheral_flags_two <= next_two_sw | two_live;
			t2_equal_q <= t2_equal;
		end
	end

	// Software-only configuration registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			peripheral_enables_one <= RESET_BYTE;
			peripheral_enables_two <= RESET_BYTE;
			per_pin_change_enable <= PIN_EN_RESET;
			timer2_period <= PERIOD_RESET;
			ext_rising_edge <= 1'b1;
		end else begin
			if (wr & sel_e1) peripheral_enables_one <= wd;
			if (wr & sel_e2) peripheral_enables_two <= wd & TWO_IMPL_MASK;
			if (wr & sel_pin) per_pin_change_enable <= wd[5:0];
			if (wr & sel_per) timer2_period <= wd;
			if (wr & sel_edge) ext_rising_edge <= wd[6];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Side effects on the serial data registers, one-cycle pulses.
	assign serial_rx_data_read = rd & (idx == IDX_RX_DATA);
	assign serial_tx_data_write = avs_write & ack & (idx == IDX_TX_DATA);

	////////////////////////////////////////////////////////////////////////////////
	// Request combination.
	wire [2:0] core_hits = core_interrupt_control[2:0] & core_interrupt_control[5:3];
	wire [7:0] one_hits = peripheral_flags_one & peripheral_enables_one;
	wire [7:0] two_hits = peripheral_flags_two & peripheral_enables_two & TWO_IMPL_MASK;
	wire periph_req = core_interrupt_control[PGE_BIT] & (|one_hits | |two_hits);
	wire any_req = core_interrupt_control[GIE_BIT] & (|core_hits | periph_req);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_irq_request <= 1'b0;
		end else begin
			core_irq_request <= any_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data mux, registered at the acknowledge edge.
	wire [7:0] rmux = sel_core ? core_interrupt_control :
		sel_f1 ? peripheral_flags_one :
		sel_f2 ? peripheral_flags_two :
		sel_e1 ? peripheral_enables_one :
		sel_e2 ? peripheral_enables_two :
		sel_pin ? {2'b00, per_pin_change_enable} :
		sel_per ? timer2_period :
		sel_edge ? {1'b0, ext_rising_edge, 6'h00} : RESET_BYTE;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ack) begin
			avs_readdata <= {24'h00_0000, rmux};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	a_global_gate: assert property (@(posedge clk) disable iff (rst)
		!core_interrupt_control[GIE_BIT] |=> !core_irq_request)
		else $error("request raised with global enable clear");
	a_group_gate: assert property (@(posedge clk) disable iff (rst)
		(!core_interrupt_control[PGE_BIT] && core_hits == 3'b000) |=> !core_irq_request)
		else $error("peripheral request passed with group enable clear");
	a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		(peripheral_flags_one[T1_BIT] && !(wr && sel_f1)) |=> peripheral_flags_one[T1_BIT])
		else $error("timer1 flag dropped without software clear");
	a_flag_set: assert property (@(posedge clk) disable iff (rst)
		events.timer0_roll |=> core_interrupt_control[T0_FLAG_BIT])
		else $error("timer0 flag not set by rollover");
	a_rx_follow: assert property (@(posedge clk) disable iff (rst)
		serial_rx_full |=> peripheral_flags_one[RX_BIT])
		else $error("receive flag does not follow buffer");
	a_tx_follow: assert property (@(posedge clk) disable iff (rst)
		!serial_tx_empty |=> !peripheral_flags_one[TX_BIT])
		else $error("transmit flag set with buffer full");
	a_unimpl_zero: assert property (@(posedge clk) disable iff (rst)
		peripheral_enables_two[3] == 1'b0 && peripheral_flags_two[1] == 1'b0)
		else $error("unimplemented bit set");
	a_port_change: assert property (@(posedge clk) disable iff (rst)
		(pin_changed[0] && per_pin_change_enable[0]) |=> core_interrupt_control[PC_FLAG_BIT])
		else $error("port change flag not set");
	a_bus_wait: assert property (@(posedge clk) disable iff (rst)
		($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	c_request: cover property (@(posedge clk) disable iff (rst) $rose(core_irq_request));
	c_periph: cover property (@(posedge clk) disable iff (rst) periph_req && any_req);
	c_clear_race: cover property (@(posedge clk) disable iff (rst)
		wr && sel_core && events.timer0_roll);
	c_ext_falling: cover property (@(posedge clk) disable iff (rst) ext_edge_evt && !ext_rising_edge);
	c_port_change: cover property (@(posedge clk) disable iff (rst) port_change_evt);

	////////////////////////////////////////////////////////////////////////////////
	// Core flag checks: each event shows in its flag one cycle later.
	// A clear port change flag that no event and no write touches must stay clear.
	a_ext_edge: assert property (@(posedge clk) disable iff (rst)
		ext_edge_evt |=> core_interrupt_control[EXT_FLAG_BIT])
		else $error("external edge flag not set");
	a_pin_gate: assert property (@(posedge clk) disable iff (rst)
		(!core_interrupt_control[PC_FLAG_BIT] && !port_change_evt && !(wr && sel_core))
		|=> !core_interrupt_control[PC_FLAG_BIT])
		else $error("port change flag set without enabled pin change");

	////////////////////////////////////////////////////////////////////////////////
	// First peripheral flag checks.
	a_cc1_set: assert property (@(posedge clk) disable iff (rst)
		cc1_evt |=> peripheral_flags_one[CC1_BIT])
		else $error("first capture flag not set");
	a_cc1_pwm: assert property (@(posedge clk) disable iff (rst)
		(cc1_mode == CC_PWM && !peripheral_flags_one[CC1_BIT] && !(wr && sel_f1))
		|=> !peripheral_flags_one[CC1_BIT])
		else $error("first capture flag set in pulse width mode");
	a_t2_match: assert property (@(posedge clk) disable iff (rst)
		t2_evt |=> peripheral_flags_one[T2_BIT])
		else $error("timer2 match flag not set");
	a_t1_set: assert property (@(posedge clk) disable iff (rst)
		events.timer1_roll |=> peripheral_flags_one[T1_BIT])
		else $error("timer1 flag not set");
	a_memw_set: assert property (@(posedge clk) disable iff (rst)
		events.mem_write_done |=> peripheral_flags_one[MEMW_BIT])
		else $error("memory write flag not set");
	a_conv_set: assert property (@(posedge clk) disable iff (rst)
		events.conversion_done |=> peripheral_flags_one[CONV_BIT])
		else $error("conversion flag not set");
	a_sync_done: assert property (@(posedge clk) disable iff (rst)
		events.sync_port_done |=> peripheral_flags_one[SYNC_BIT])
		else $error("synchronous port flag not set");
	a_clear_zero: assert property (@(posedge clk) disable iff (rst)
		(wr && sel_f1 && !wd[T1_BIT] && !events.timer1_roll) |=> !peripheral_flags_one[T1_BIT])
		else $error("write of zero did not clear timer1 flag");

	////////////////////////////////////////////////////////////////////////////////
	// Second peripheral flag checks.
	a_osc_fail: assert property (@(posedge clk) disable iff (rst)
		events.osc_fail |=> peripheral_flags_two[OSC_BIT])
		else $error("oscillator fail flag not set");
	a_cmp_one: assert property (@(posedge clk) disable iff (rst)
		cmp1_evt |=> peripheral_flags_two[CMP1_BIT])
		else $error("comparator one flag not set");
	a_cmp_two: assert property (@(posedge clk) disable iff (rst)
		cmp2_evt |=> peripheral_flags_two[CMP2_BIT])
		else $error("comparator two flag not set");
	a_display_live: assert property (@(posedge clk) disable iff (rst)
		events.display_irq |=> peripheral_flags_two[DISP_BIT])
		else $error("display flag does not follow its source");
	a_low_voltage: assert property (@(posedge clk) disable iff (rst)
		events.low_voltage |=> peripheral_flags_two[LVD_BIT])
		else $error("low voltage flag not set");
	a_cc2_set: assert property (@(posedge clk) disable iff (rst)
		cc2_evt |=> peripheral_flags_two[CC2_BIT])
		else $error("second capture flag not set");

	////////////////////////////////////////////////////////////////////////////////
	// Request and bus checks.
	// The acknowledge is a single cycle; a held request completes again every second cycle.
	a_periph_req: assert property (@(posedge clk) disable iff (rst)
		(core_interrupt_control[GIE_BIT] && core_interrupt_control[PGE_BIT] && |one_hits)
		|=> core_irq_request)
		else $error("enabled peripheral flag raised no request");
	a_ack_single: assert property (@(posedge clk) disable iff (rst)
		ack |=> !ack)
		else $error("acknowledge longer than one cycle");
	a_rx_pulse: assert property (@(posedge clk) disable iff (rst)
		serial_rx_data_read |-> (avs_read && !avs_waitrequest))
		else $error("receive read pulse outside a completing read");
	a_tx_pulse: assert property (@(posedge clk) disable iff (rst)
		serial_tx_data_write |-> (avs_write && !avs_waitrequest))
		else $error("transmit write pulse outside a completing write");
	a_rdata_upper: assert property (@(posedge clk) disable iff (rst)
		avs_readdata[31:8] == 24'h00_0000)
		else $error("upper read data bits not zero");

endmodule : irq_flag_logic

// ### tb/periph_model.sv
// Behavioural model of the peripheral event sources and the serial buffers.
`timescale 1ns/1ps
module periph_model
	import irq_flags_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire event_pulses_t fire,
	input wire logic rx_load,
	input wire logic serial_rx_data_read,
	input wire logic serial_tx_data_write,
	output event_pulses_t events,
	output logic serial_rx_full,
	output logic serial_tx_empty
);
	logic [3:0] tx_busy;
	// Events leave one cycle after a request; a written byte drains in eight cycles.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			events <= '0;
			serial_rx_full <= 1'b0;
			tx_busy <= 4'h0;
		end else begin
			events <= fire;
			if (rx_load) serial_rx_full <= 1'b1;
			else if (serial_rx_data_read) serial_rx_full <= 1'b0;
			if (serial_tx_data_write) tx_busy <= 4'h8;
			else if (tx_busy != 4'h0) tx_busy <= tx_busy - 4'h1;
		end
	end
	// The transmit buffer is empty whenever no byte is draining.
	assign serial_tx_empty = (tx_busy == 4'h0);
endmodule : periph_model

// ### tb/tb_mcu_interrupt_enable_flag_logic.sv
// Self-checking testbench of the interrupt enable and flag logic.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module tb_mcu_interrupt_enable_flag_logic
	import irq_flags_pkg::*;
;
	logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, ext_pin = 0, rx_load = 0;
	logic cmp1 = 0, cmp2 = 0, rd_pulse, wr_pulse, rx_full, tx_empty, irq, wait_req;
	logic [9:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, rdata;
	logic [3:0] avs_byteenable = 4'hf;
	logic [5:0] port_pins = '0;
	logic [7:0] t2 = 8'h00, v;
	capcmp_mode_t cc1_mode = CC_CAPTURE, cc2_mode = CC_CAPTURE;
	event_pulses_t fire = '0, events;
	int miscompares = 0, tests_run = 0;
	irq_flag_logic dut_u (.clk(clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(rdata), .avs_waitrequest(wait_req),
		.ext_pin(ext_pin), .port_pins(port_pins), .comparator_one_output(cmp1),
		.comparator_two_output(cmp2), .events(events), .cc1_mode(cc1_mode),
		.cc2_mode(cc2_mode), .timer2_count(t2), .serial_rx_full(rx_full),
		.serial_tx_empty(tx_empty), .serial_rx_data_read(rd_pulse),
		.serial_tx_data_write(wr_pulse), .core_irq_request(irq));
	periph_model model_u (.clk(clk), .rst(rst), .fire(fire), .rx_load(rx_load),
		.serial_rx_data_read(rd_pulse), .serial_tx_data_write(wr_pulse), .events(events),
		.serial_rx_full(rx_full), .serial_tx_empty(tx_empty));
	// The clock toggles every half period of 50 ns.
	initial begin
		forever #50 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Prints the verdict and ends the run.
	task automatic final_report();
		if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	// Waits the given number of rising edges.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// One Avalon-MM transfer; held until a rising edge samples waitrequest low.
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h00_0000, d};
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 20);
		if (n >= 20) begin
			miscompares++;
			final_report();
		end
		v = rdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	// Reads a register and compares it under a mask.
	task automatic rchk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		`CHK(v & m, e)
	endtask : rchk
	////////////////////////////////////////////////////////////////////////////////
	// Reset values, an unmapped place and the unimplemented enable bits.
	task automatic t_regs();
		rchk(IDX_CORE_CTRL, 8'hff, 8'h00);
		rchk(IDX_PEN_ONE, 8'hff, 8'h00);
		rchk(IDX_PEN_TWO, 8'hff, 8'h00);
		rchk(IDX_TIMER2_PERIOD, 8'hff, 8'hff);
		rchk(8'h20, 8'hff, 8'h00);
		bus(1'b1, IDX_PEN_TWO, 8'hff);
		rchk(IDX_PEN_TWO, 8'hff, TWO_IMPL_MASK);
		bus(1'b1, IDX_PEN_ONE, 8'hef);
		rchk(IDX_PEN_ONE, 8'hff, 8'hef);
	endtask : t_regs
	// Peripheral flags set with global and group enable clear, stay set, then gate in order.
	task automatic t_periph();
		@(posedge clk);
		fire <= '{timer1_roll: 1, cc1_capture: 1, cc2_capture: 1, mem_write_done: 1,
			conversion_done: 1, sync_port_done: 1, osc_fail: 1, low_voltage: 1, default: 0};
		@(posedge clk);
		fire <= '0;
		cyc(20);
		`CHK(irq, 1'b0)
		rchk(IDX_PFLAGS_ONE, 8'hff, 8'hdd);
		rchk(IDX_PFLAGS_TWO, 8'hff, 8'h85);
		bus(1'b1, IDX_CORE_CTRL, 8'h80);
		cyc(3);
		`CHK(irq, 1'b0)
		bus(1'b1, IDX_CORE_CTRL, 8'hc0);
		cyc(3);
		`CHK(irq, 1'b1)
		bus(1'b1, IDX_PFLAGS_ONE, 8'h00);
		bus(1'b1, IDX_PFLAGS_TWO, 8'h00);
		rchk(IDX_PFLAGS_ONE, 8'hff, 8'h10);
		cyc(3);
		`CHK(irq, 1'b0)
	endtask : t_periph
	// Serial buffer flags, comparator change and timer2 equality.
	task automatic t_live();
		@(posedge clk);
		rx_load <= 1'b1;
		fire <= '{display_irq: 1, default: 0};
		t2 <= 8'hff;
		cmp2 <= 1'b1;
		cmp1 <= 1'b1;
		@(posedge clk);
		rx_load <= 1'b0;
		cyc(8);
		rchk(IDX_PFLAGS_ONE, 8'h22, 8'h22);
		rchk(IDX_PFLAGS_TWO, 8'h70, 8'h70);
		fire <= '0;
		bus(1'b0, IDX_RX_DATA, 8'h00);
		cyc(3);
		rchk(IDX_PFLAGS_ONE, 8'h20, 8'h00);
		bus(1'b1, IDX_TX_DATA, 8'h55);
		rchk(IDX_PFLAGS_ONE, 8'h10, 8'h00);
		bus(1'b1, IDX_PFLAGS_ONE, 8'h00);
		bus(1'b1, IDX_PFLAGS_TWO, 8'h00);
	endtask : t_live
	// Core sources: timer0 rollover, external edge and port change.
	task automatic t_core();
		bus(1'b1, IDX_CORE_CTRL, 8'ha0);
		@(posedge clk);
		fire <= '{timer0_roll: 1, default: 0};
		@(posedge clk);
		fire <= '0;
		cyc(4);
		`CHK(irq, 1'b1)
		rchk(IDX_CORE_CTRL, 8'hff, 8'ha4);
		bus(1'b1, IDX_CORE_CTRL, 8'h90);
		ext_pin <= 1'b1;
		cyc(8);
		rchk(IDX_CORE_CTRL, 8'hff, 8'h92);
		`CHK(irq, 1'b1)
		bus(1'b1, IDX_PIN_CHANGE_EN, 8'h21);
		bus(1'b1, IDX_CORE_CTRL, 8'h88);
		port_pins <= 6'h20;
		cyc(8);
		rchk(IDX_CORE_CTRL, 8'hff, 8'h89);
		`CHK(irq, 1'b1)
		bus(1'b1, IDX_EDGE_SELECT, 8'h00);
		bus(1'b1, IDX_CORE_CTRL, 8'h90);
		ext_pin <= 1'b0;
		cyc(8);
		rchk(IDX_CORE_CTRL, 8'hff, 8'h92);
	endtask : t_core
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence with reset held for ten cycles, and an overall time limit.
	initial begin
		cyc(10);
		rst <= 1'b0;
		t_regs();
		t_periph();
		t_live();
		t_core();
		final_report();
	end
	initial begin
		#5ms;
		miscompares++;
		final_report();
	end
endmodule : tb_mcu_interrupt_enable_flag_logic
